// ---- rtl/fcs_pkg.sv ----
package fcs_pkg;

    // port roles and link modes
    localparam logic ROLE_MASTER = 1'b0;
    localparam logic ROLE_SLAVE = 1'b1;
    localparam logic LINK_FIELDBUS = 1'b0;
    localparam logic LINK_PROG = 1'b1;

    // bit rate codes
    localparam logic [3:0] RATE_19K2 = 4'h0;
    localparam logic [3:0] RATE_1M5 = 4'h6;
    localparam logic [3:0] RATE_12M = 4'h9;
    localparam logic [3:0] RATE_MAX = 4'h9;

    // values after reset
    localparam logic [6:0] RST_ADDR = 7'h02;
    localparam logic [3:0] RST_RATE = RATE_1M5;
    localparam logic RST_ROLE = ROLE_MASTER;
    localparam logic RST_ISO = 1'b0;

    // clock and timing
    localparam int CLK_MHZ = 200;
    localparam int EXT_MIN_CYCLE_US = 1000;
    localparam int EXT_MIN_CYCLES = EXT_MIN_CYCLE_US * CLK_MHZ;
    localparam int DRV_CYCLE_US = 1000;
    localparam int DRV_CYCLES = DRV_CYCLE_US * CLK_MHZ;
    localparam int CNT_W = 24;
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
    localparam logic [2:0] MISS_LIMIT = 3'h3;
    localparam logic [2:0] LOCK_NEED = 3'h2;
    localparam logic [2:0] CNT3_ZERO = 3'h0;

    typedef struct packed {
        logic role;
        logic iso;
        logic [6:0] addr;
        logic [3:0] rate;
        logic [CNT_W-1:0] cycle;
    } fcs_port_cfg_type;

    typedef enum logic [4:0] {
        SRC_DRIVE = 5'b00001,
        SRC_SLAVE1 = 5'b00010,
        SRC_SLAVE2 = 5'b00100,
        SRC_MASTER = 5'b01000,
        SRC_REPL = 5'b10000
    } fcs_src_type;

endpackage

// ---- rtl/fcs_sync_selector.sv ----
`timescale 1ns/1ps
// Function
// RULE_01 - two fieldbus ports, up to 12 Mbit/s
// RULE_02 - reset default: master, address 2, 1.5M
// RULE_03 - second port may be programming link
// RULE_04 - isochronous cycle length configurable, equidistant
// RULE_05 - master sends global control each cycle
// RULE_06 - slave free-runs through missing global controls
// RULE_07 - internal drive bus always isochronous master
// RULE_08 - iso slave plus iso master locks drive
// RULE_09 - iso slave plus non-iso uses slave cycle
// RULE_10 - application sees slave synchronisation state
// RULE_11 - two iso masters share drive cycle
// RULE_12 - single iso master sets the timebase
// RULE_13 - no iso port uses drive cycle
// RULE_14 - slave port answers only master requests
// RULE_15 - no lock falls back to replacement cycle
// RULE_16 - external cycles below 1 ms rejected
// RULE_17 - lock flag with loss-of-lock event
module fcs_sync_selector (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // configuration load
    input wire logic cfg_load_i,
    input wire fcs_pkg::fcs_port_cfg_type first_fieldbus_port_cfg_i,
    input wire fcs_pkg::fcs_port_cfg_type second_fieldbus_port_cfg_i,
    input wire logic second_prog_link_i,
    input wire logic [fcs_pkg::CNT_W-1:0] drive_cycle_i,
    // global control frames received on slave ports (pins)
    input wire logic first_gc_rx_i,
    input wire logic second_gc_rx_i,
    // active configuration
    output fcs_pkg::fcs_port_cfg_type first_fieldbus_port_cfg_o,
    output fcs_pkg::fcs_port_cfg_type second_fieldbus_port_cfg_o,
    output logic second_prog_link_o,
    output logic cfg_err_o,
    // timebase
    output logic first_gc_tx_o,
    output logic second_gc_tx_o,
    output logic drive_gc_tx_o,
    output logic app_tick_o,
    output logic [4:0] src_o,
    // status
    output logic slave_sync_o,
    output logic locked_o,
    output logic lock_lost_o
);

    fcs_pkg::fcs_port_cfg_type p1_q, p2_q;
    logic prog_q;
    logic [fcs_pkg::CNT_W-1:0] dcyc_q;
    logic err_q;
    logic [1:0] gc1_s, gc2_s;
    logic [fcs_pkg::CNT_W-1:0] tb_cnt_q, slv_cnt_q;
    logic [2:0] miss_q, good_q;
    logic lock_q, tick_q, g1_q, g2_q, gd_q, lost_q;
    fcs_pkg::fcs_src_type src_q, src_d;

    function automatic logic rate_ok(input logic [3:0] r, input logic prog);
        rate_ok = (r <= fcs_pkg::RATE_MAX) && (prog || r != fcs_pkg::RATE_19K2); // RULE_01 RULE_03
    endfunction

    // only external ports are held to the floor; the drive bus may run faster
    function automatic logic cyc_ok(input logic [fcs_pkg::CNT_W-1:0] c);
        cyc_ok = c >= fcs_pkg::CNT_W'(fcs_pkg::EXT_MIN_CYCLES); // RULE_16
    endfunction

    // a bad configuration is refused whole; the old one stays active
    wire logic p1_ok = rate_ok(first_fieldbus_port_cfg_i.rate, 1'b0)
        && (!first_fieldbus_port_cfg_i.iso || cyc_ok(first_fieldbus_port_cfg_i.cycle));
    wire logic p2_ok = rate_ok(second_fieldbus_port_cfg_i.rate, second_prog_link_i)
        && (second_prog_link_i || !second_fieldbus_port_cfg_i.iso
            || cyc_ok(second_fieldbus_port_cfg_i.cycle));
    wire logic m1_iso = first_fieldbus_port_cfg_i.iso
        && first_fieldbus_port_cfg_i.role == fcs_pkg::ROLE_MASTER;
    wire logic m2_iso = !second_prog_link_i && second_fieldbus_port_cfg_i.iso
        && second_fieldbus_port_cfg_i.role == fcs_pkg::ROLE_MASTER;
    wire logic s1_iso = first_fieldbus_port_cfg_i.iso
        && first_fieldbus_port_cfg_i.role == fcs_pkg::ROLE_SLAVE;
    wire logic s2_iso = !second_prog_link_i && second_fieldbus_port_cfg_i.iso
        && second_fieldbus_port_cfg_i.role == fcs_pkg::ROLE_SLAVE;
    // iso master cycles must equal the drive bus cycle
    wire logic m_ok = (!m1_iso || first_fieldbus_port_cfg_i.cycle == drive_cycle_i)
        && (!m2_iso || second_fieldbus_port_cfg_i.cycle == drive_cycle_i); // RULE_08 RULE_11 RULE_12
    wire logic cfg_ok = p1_ok && p2_ok && m_ok && !(s1_iso && s2_iso)
        && drive_cycle_i != fcs_pkg::CNT_ZERO;
    wire logic do_load = cfg_load_i && cfg_ok;

    // active roles
    wire logic a_s1 = p1_q.iso && p1_q.role == fcs_pkg::ROLE_SLAVE;
    wire logic a_s2 = !prog_q && p2_q.iso && p2_q.role == fcs_pkg::ROLE_SLAVE;
    wire logic a_m1 = p1_q.iso && p1_q.role == fcs_pkg::ROLE_MASTER;
    wire logic a_m2 = !prog_q && p2_q.iso && p2_q.role == fcs_pkg::ROLE_MASTER;
    wire logic any_s = a_s1 || a_s2;
    wire logic [fcs_pkg::CNT_W-1:0] s_cyc = a_s1 ? p1_q.cycle : p2_q.cycle;
    wire logic gc_in = a_s1 ? gc1_s[1] : gc2_s[1];

    // slave cycle watchdog: runs one slave period, restarted by each frame
    // lock wants two frames in a row, so one stray pulse cannot steer the drives
    wire logic slv_wrap = slv_cnt_q >= s_cyc - fcs_pkg::CNT_ONE;
    wire logic slv_event = any_s && (gc_in || slv_wrap); // RULE_06
    wire logic new_lock = any_s && (lock_q || good_q >= fcs_pkg::LOCK_NEED);
    wire logic drop_lock = !any_s || (slv_wrap && !gc_in && miss_q >= fcs_pkg::MISS_LIMIT);

    // timebase tick: slave event when locked, else own drive counter
    wire logic tb_wrap = tb_cnt_q >= dcyc_q - fcs_pkg::CNT_ONE;
    wire logic tick = (any_s && lock_q) ? slv_event : tb_wrap; // RULE_09 RULE_15 RULE_13

    // an unlocked slave port reports the replacement cycle, never the slave itself
    function automatic fcs_pkg::fcs_src_type pick_src(input logic slave, input logic locked,
        input logic first, input logic master);
        if (slave && locked && first) begin
            pick_src = fcs_pkg::SRC_SLAVE1; // RULE_09
        end else if (slave && locked) begin
            pick_src = fcs_pkg::SRC_SLAVE2; // RULE_09
        end else if (slave) begin
            pick_src = fcs_pkg::SRC_REPL; // RULE_15
        end else if (master) begin
            pick_src = fcs_pkg::SRC_MASTER; // RULE_11 RULE_12
        end else begin
            pick_src = fcs_pkg::SRC_DRIVE; // RULE_13
        end
    endfunction

    assign src_d = pick_src(any_s, lock_q, a_s1, a_m1 || a_m2); // RULE_08

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            p1_q <= '{fcs_pkg::RST_ROLE, fcs_pkg::RST_ISO, fcs_pkg::RST_ADDR,
                      fcs_pkg::RST_RATE, fcs_pkg::CNT_ZERO}; // RULE_02
            p2_q <= '{fcs_pkg::RST_ROLE, fcs_pkg::RST_ISO, fcs_pkg::RST_ADDR,
                      fcs_pkg::RST_RATE, fcs_pkg::CNT_ZERO}; // RULE_02
            prog_q <= 1'b0;
            dcyc_q <= fcs_pkg::CNT_W'(fcs_pkg::DRV_CYCLES);
            err_q <= 1'b0;
        end else begin
            if (do_load) begin
                p1_q <= first_fieldbus_port_cfg_i;
                p2_q <= second_fieldbus_port_cfg_i;
                prog_q <= second_prog_link_i; // RULE_03
                dcyc_q <= drive_cycle_i; // RULE_04
            end
            if (cfg_load_i) begin
                err_q <= !cfg_ok; // RULE_16
            end
        end
    end

    // global control inputs come from pins: two flops first
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gc1_s <= 2'b00;
            gc2_s <= 2'b00;
        end else begin
            gc1_s <= {gc1_s[0], first_gc_rx_i};
            gc2_s <= {gc2_s[0], second_gc_rx_i};
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            slv_cnt_q <= fcs_pkg::CNT_ZERO;
            miss_q <= fcs_pkg::CNT3_ZERO;
            good_q <= fcs_pkg::CNT3_ZERO;
            lock_q <= 1'b0;
        end else if (!any_s || do_load) begin
            slv_cnt_q <= fcs_pkg::CNT_ZERO;
            miss_q <= fcs_pkg::CNT3_ZERO;
            good_q <= fcs_pkg::CNT3_ZERO;
            lock_q <= 1'b0;
        end else begin
            slv_cnt_q <= slv_event ? fcs_pkg::CNT_ZERO : slv_cnt_q + fcs_pkg::CNT_ONE; // RULE_05
            if (gc_in) begin
                miss_q <= fcs_pkg::CNT3_ZERO;
                good_q <= (good_q == 3'h7) ? good_q : good_q + 3'h1;
            end else if (slv_wrap) begin
                miss_q <= (miss_q == 3'h7) ? miss_q : miss_q + 3'h1; // RULE_06
                good_q <= fcs_pkg::CNT3_ZERO;
            end
            lock_q <= new_lock && !drop_lock; // RULE_17
        end
    end

    // drive bus is always an isochronous master; its frame follows the timebase
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tb_cnt_q <= fcs_pkg::CNT_ZERO;
            tick_q <= 1'b0;
            g1_q <= 1'b0;
            g2_q <= 1'b0;
            gd_q <= 1'b0;
            lost_q <= 1'b0;
            src_q <= fcs_pkg::SRC_DRIVE;
        end else begin
            tb_cnt_q <= tick ? fcs_pkg::CNT_ZERO : tb_cnt_q + fcs_pkg::CNT_ONE; // RULE_15
            tick_q <= tick;
            gd_q <= tick; // RULE_07
            g1_q <= tick && a_m1; // RULE_05 RULE_08
            g2_q <= tick && a_m2; // RULE_05 RULE_08
            // a reload drops lock on purpose and raises no loss event
            lost_q <= lock_q && !(new_lock && !drop_lock) && !do_load; // RULE_17
            src_q <= src_d;
        end
    end

    // every output is a plain copy of a register
    assign first_fieldbus_port_cfg_o = p1_q;
    assign second_fieldbus_port_cfg_o = p2_q;
    assign second_prog_link_o = prog_q;
    assign cfg_err_o = err_q;
    assign first_gc_tx_o = g1_q;
    assign second_gc_tx_o = g2_q;
    assign drive_gc_tx_o = gd_q;
    assign app_tick_o = tick_q;
    assign src_o = src_q;
    assign slave_sync_o = lock_q; // RULE_10
    assign locked_o = lock_q; // RULE_17
    assign lock_lost_o = lost_q;

endmodule

// ---- bench/fcs_sync_selector_sva.sv ----
`timescale 1ns/1ps
module fcs_sync_selector_sva (
    // watched ports
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic cfg_load_i,
    input wire fcs_pkg::fcs_port_cfg_type first_fieldbus_port_cfg_i,
    input wire fcs_pkg::fcs_port_cfg_type first_fieldbus_port_cfg_o,
    input wire logic cfg_err_o,
    input wire logic first_gc_tx_o,
    input wire logic second_gc_tx_o,
    input wire logic drive_gc_tx_o,
    input wire logic app_tick_o,
    input wire logic [4:0] src_o,
    input wire logic slave_sync_o,
    input wire logic locked_o,
    input wire logic lock_lost_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_bad_rate;
        cfg_load_i && first_fieldbus_port_cfg_i.rate > 4'h9;
    endsequence
    sequence s_short_iso;
        cfg_load_i && first_fieldbus_port_cfg_i.iso
            && first_fieldbus_port_cfg_i.cycle < 24'h030d40;
    endsequence
    // the pulse comes with the fall of lock; a reload drops lock with no pulse
    sequence s_drop;
        $past(locked_o) && !locked_o;
    endsequence
    AST_TICK_PAIR: assert property (app_tick_o == drive_gc_tx_o)
        else $error("drive tick apart from application tick");
    AST_GC_TICK: assert property ((first_gc_tx_o || second_gc_tx_o) |-> drive_gc_tx_o)
        else $error("global control apart from drive tick");
    AST_SYNC_FLAG: assert property (slave_sync_o == locked_o)
        else $error("sync flag differs from lock");
    AST_SRC_ONEHOT: assert property ($onehot(src_o))
        else $error("source not one-hot");
    AST_LOCK_SRC: assert property (locked_o |=> src_o[1] || src_o[2])
        else $error("locked without slave source");
    AST_LOST: assert property (lock_lost_o |-> s_drop ##1 !lock_lost_o)
        else $error("loss pulse without lock drop");
    AST_BAD_RATE: assert property (s_bad_rate |=> cfg_err_o)
        else $error("rate above limit accepted");
    AST_SHORT_CYCLE: assert property (s_short_iso |=> cfg_err_o)
        else $error("short external cycle accepted");
    AST_CFG_HOLD: assert property (!cfg_load_i |=> $stable(first_fieldbus_port_cfg_o))
        else $error("config changed without load");
endmodule
bind fcs_sync_selector fcs_sync_selector_sva u_sva (.*);

// ---- bench/fcs_gc_master_model.sv ----
`timescale 1ns/1ps
module fcs_gc_master_model #(
    parameter int PERIOD = 7
) (
    input wire logic sys_clk_i,
    input wire logic en_i,
    output logic gc_o
);
    int cnt = 0;
    initial gc_o = 1'b0;
    // one global control frame per period, evenly spaced
    // the device's slave port only ever listens to these frames
    always @(posedge sys_clk_i) begin
        cnt <= (en_i && cnt < PERIOD - 1) ? cnt + 1 : 0;
        gc_o <= en_i && cnt == PERIOD - 1;
    end
endmodule

// ---- bench/fcs_sync_selector_tb.sv ----
`timescale 1ns/1ps
module fcs_sync_selector_tb;
    typedef struct packed {
        logic [1:0] m1, m2;
        logic [3:0] r1, r2;
        logic pg;
        logic [23:0] c1, c2, dc;
        logic er;
        logic [4:0] sr;
    } fcs_row_type;
    localparam logic [23:0] Z = 24'h000000;
    localparam logic [23:0] D = 24'h000010;
    localparam logic [23:0] MC = 24'h030d40;
    localparam logic [23:0] MS = 24'h030d3f;
    localparam int GP = 7;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ld = 1'b0;
    logic pg = 1'b0;
    logic gen = 1'b0;
    logic g1, err, app;
    logic [23:0] dcyc = D;
    logic [4:0] src;
    logic g1tx, g2tx, lk, ss, lost, pgo;
    fcs_pkg::fcs_port_cfg_type cfg1 = '0;
    fcs_pkg::fcs_port_cfg_type cfg2 = '0;
    fcs_pkg::fcs_port_cfg_type co1, co2;
    int err_count = 0;
    int checks = 0;
    int n;
    fcs_row_type rows[11];
    fcs_row_type lrows[2];
    fcs_gc_master_model #(.PERIOD(GP)) gcm (.sys_clk_i(sys_clk), .en_i(gen), .gc_o(g1));
    fcs_sync_selector dut (.sys_clk_i(sys_clk), .sys_rst_i(rst), .cfg_load_i(ld),
        .first_fieldbus_port_cfg_i(cfg1), .second_fieldbus_port_cfg_i(cfg2),
        .second_prog_link_i(pg), .drive_cycle_i(dcyc), .first_gc_rx_i(g1),
        .second_gc_rx_i(g1), .first_fieldbus_port_cfg_o(co1),
        .second_fieldbus_port_cfg_o(co2), .second_prog_link_o(pgo), .cfg_err_o(err),
        .first_gc_tx_o(g1tx), .second_gc_tx_o(g2tx), .drive_gc_tx_o(), .app_tick_o(app),
        .src_o(src), .slave_sync_o(ss), .locked_o(lk), .lock_lost_o(lost));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic chk(string n, logic [36:0] e, logic [36:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic load(fcs_row_type r);
        cfg1 = {r.m1, 7'h05, r.r1, r.c1};
        cfg2 = {r.m2, 7'h05, r.r2, r.c2};
        pg = r.pg;
        dcyc = r.dc;
        ld = 1'b1;
        @(negedge sys_clk);
        ld = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic period(output int p);
        p = 0;
        while (app !== 1'b1 && p < 40) begin
            @(negedge sys_clk);
            p++;
        end
        p = 0;
        do begin
            @(negedge sys_clk);
            p++;
        end while (app !== 1'b1 && p < 40);
    endtask
    task automatic reset_check;
        rst = 1'b1;
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        chk("port1 default", {2'b00, 7'h02, 4'h6, Z}, co1);
        chk("port2 default", {2'b00, 7'h02, 4'h6, Z}, co2);
        chk("source default", 5'h01, src);
    endtask
    // budget is a few hundred cycles; this leaves ample margin
    initial begin
        #20000;
        err_count++;
        results();
    end
    initial begin
        rows = '{
            '{2'b00, 2'b00, 4'h6, 4'h6, 1'b0, Z, Z, D, 1'b0, 5'h01},
            '{2'b10, 2'b10, 4'h9, 4'h9, 1'b0, Z, Z, D, 1'b0, 5'h01},
            '{2'b00, 2'b00, 4'ha, 4'h6, 1'b0, Z, Z, D, 1'b1, 5'h00},
            '{2'b00, 2'b00, 4'h6, 4'h0, 1'b1, Z, Z, D, 1'b0, 5'h01},
            '{2'b00, 2'b00, 4'h6, 4'h0, 1'b0, Z, Z, D, 1'b1, 5'h00},
            '{2'b11, 2'b00, 4'h6, 4'h6, 1'b0, MS, Z, D, 1'b1, 5'h00},
            '{2'b11, 2'b00, 4'h6, 4'h6, 1'b0, MC, Z, D, 1'b0, 5'h10},
            '{2'b11, 2'b11, 4'h6, 4'h6, 1'b0, MC, MC, MC, 1'b1, 5'h00},
            '{2'b01, 2'b00, 4'h6, 4'h6, 1'b0, MC, Z, MC, 1'b0, 5'h08},
            '{2'b01, 2'b00, 4'h6, 4'h6, 1'b0, MC, Z, MS, 1'b1, 5'h00},
            '{2'b01, 2'b01, 4'h6, 4'h6, 1'b0, MC, MC, MC, 1'b0, 5'h08}
        };
        reset_check();
        foreach (rows[i]) begin
            load(rows[i]);
            chk("refused", rows[i].er, err);
            if (rows[i].er === 1'b0) begin
                chk("source", rows[i].sr, src);
                chk("port1", {rows[i].m1, 7'h05, rows[i].r1, rows[i].c1}, co1);
                chk("prog link", rows[i].pg, pgo);
            end
        end
        load(rows[0]);
        gen = 1'b1;
        period(n);
        chk("tick period", D, 37'(n));
        chk("source with frames", 5'h01, src);
        lrows[0] = '{2'b11, 2'b01, 4'h6, 4'h6, 1'b0, MC, MC, MC, 1'b0, 5'h02};
        lrows[1] = '{2'b01, 2'b11, 4'h6, 4'h6, 1'b0, MC, MC, MC, 1'b0, 5'h04};
        foreach (lrows[i]) begin
            load(lrows[i]);
            repeat (40) @(negedge sys_clk);
            chk("locked", 1'b1, lk);
            chk("sync state", 1'b1, ss);
            chk("locked source", lrows[i].sr, src);
            period(n);
            chk("slave tick period", 37'(GP), 37'(n));
            chk("gc to iso master", 1'b1, g1tx ^ g2tx);
            gen = 1'b0;
            repeat (30) @(negedge sys_clk);
            chk("lock kept without frames", 1'b1, lk);
            chk("no loss event", 1'b0, lost);
            load(rows[0]);
            chk("lock dropped by reload", 1'b0, lk);
            gen = 1'b1;
        end
        cfg1 = {2'b00, 7'h07, 4'h6, Z};
        ld = 1'b1;
        @(negedge sys_clk);
        cfg1 = {2'b00, 7'h09, 4'ha, Z};
        @(negedge sys_clk);
        ld = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("refused after accept", 1'b1, err);
        chk("port1 kept", {2'b00, 7'h07, 4'h6, Z}, co1);
        reset_check();
        results();
    end
endmodule
